// ===== atc_top.sv
// Acquisition trigger control: start gating and reference marking.
// Assumes an APB master, pins from outside, IQ samples on pclk.
`timescale 1ns/1ps
`default_nettype none
module atc_top
(
    // Clock, reset, enable
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               pclk_en,
    // APB slave
    input  wire logic [7:0]         paddr,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Trigger pins
    input  wire atc_pkg::atc_lines_t trig_lines,
    // IQ samples
    input  wire atc_pkg::atc_iq_t   iq_in,
    // Acquisition outputs
    output logic                    acq_run,
    output logic                    ref_mark
);
    // Configuration registers
    logic [15:0] ref_cfg;   // Reference mode, source, edge, slope
    logic [5:0]  start_cfg; // Start mode, source, edge
    logic [15:0] pretrig;   // Pretrigger sample count
    logic [31:0] iq_level;  // Power threshold
    // Sequencer state
    atc_pkg::atc_state_t st;
    atc_pkg::atc_state_t next_st;
    logic [15:0] pre_cnt;   // Samples counted while filling the pretrigger window
    logic        soft_pend; // Software trigger waiting
    logic        ref_seen;  // Reference marked since arm
    logic [atc_pkg::NUM_LINES-1:0] lines_f;    // Filtered lines
    logic [atc_pkg::NUM_LINES-1:0] lines_prev; // Previous levels
    logic        iq_prev_above; // Last power above level
    logic        iq_primed;     // One sample seen this record

    // Edge hit on a chosen line with range guard
    function automatic logic edge_hit(
        input logic [atc_pkg::NUM_LINES-1:0] now,
        input logic [atc_pkg::NUM_LINES-1:0] prev,
        input logic [3:0]                    sel,
        input logic                          fall);
        logic hit;
        hit = 1'b0;
        if (sel <= atc_pkg::SRC_LAST) // [R3] [R4]
        begin
            hit = fall ? (prev[sel] & ~now[sel]) : (~prev[sel] & now[sel]); // [R5]
        end
        return hit;
    endfunction

    // Pin synchroniser
    atc_pin_sync u_sync
    (
        .pclk      (pclk),
        .presetn   (presetn),
        .pclk_en   (pclk_en),
        .pin_in    (trig_lines),
        .level_out (lines_f)
    );

    // Field decode
    wire atc_pkg::atc_ref_mode_t ref_mode =
        atc_pkg::atc_ref_mode_t'(ref_cfg[atc_pkg::REF_MODE_LSB +: 2]);
    wire logic [3:0] ref_src    = ref_cfg[atc_pkg::REF_SRC_LSB +: 4];
    wire logic       ref_fall   = ref_cfg[atc_pkg::REF_EDGE_BIT];
    wire logic       slope_fall = ref_cfg[atc_pkg::REF_SLOPE_BIT];
    wire logic [7:0] iq_src     = ref_cfg[atc_pkg::REF_IQSRC_LSB +: 8];
    wire logic       start_dig  = start_cfg[atc_pkg::START_MODE_BIT];
    wire logic [3:0] start_src  = start_cfg[atc_pkg::START_SRC_LSB +: 4];
    wire logic       start_fall = start_cfg[atc_pkg::START_EDGE_BIT];

    // APB decode
    wire logic setup    = psel & ~penable;
    wire logic done     = psel & penable & pready & pclk_en;
    wire logic wr       = done & pwrite;
    wire logic hit_ctrl = paddr == atc_pkg::OFF_CTRL;
    wire logic hit_ref  = paddr == atc_pkg::OFF_REF_CFG;
    wire logic hit_strt = paddr == atc_pkg::OFF_START_CFG;
    wire logic hit_pre  = paddr == atc_pkg::OFF_PRETRIG;
    wire logic hit_lvl  = paddr == atc_pkg::OFF_IQ_LEVEL;
    wire logic hit_stat = paddr == atc_pkg::OFF_STATUS;
    wire logic addr_ok  = hit_ctrl | hit_ref | hit_strt | hit_pre |
                          hit_lvl | hit_stat;
    wire logic arm_wr   = wr & hit_ctrl & pwdata[atc_pkg::CTRL_ARM];
    wire logic soft_wr  = wr & hit_ctrl & pwdata[atc_pkg::CTRL_SOFT];
    wire logic abort_wr = wr & hit_ctrl & pwdata[atc_pkg::CTRL_ABORT];

    // Digital edges on the chosen lines
    wire logic ref_dig_hit   = edge_hit(lines_f, lines_prev, ref_src, ref_fall);
    wire logic start_dig_hit = edge_hit(lines_f, lines_prev, start_src, start_fall);

    // Complex power and crossing
    wire logic signed [31:0] i_sq = iq_in.i * iq_in.i;
    wire logic signed [31:0] q_sq = iq_in.q * iq_in.q;
    wire logic [32:0] iq_power = {1'b0, i_sq} + {1'b0, q_sq};
    wire logic iq_above  = iq_power > {1'b0, iq_level};
    wire logic iq_src_ok = iq_src == atc_pkg::IQ_SRC_ONLY; // [R10]
    wire logic iq_cross  = iq_primed & (slope_fall ? (iq_prev_above & ~iq_above)
                                                   : (~iq_prev_above & iq_above));
    wire logic iq_hit    = iq_in.valid & iq_src_ok & iq_cross; // [R9]
    wire logic iq_err    = (ref_mode == atc_pkg::ATC_REF_IQ) & ~iq_src_ok;

    // Pretrigger window filled
    wire logic pre_full = pre_cnt >= pretrig; // [R6]
    wire logic in_ref   = st == atc_pkg::ST_WAIT_REF;

    // Reference event by mode, only one mode active
    logic ref_event;
    always_comb
    begin
        case (ref_mode) // [R14]
            atc_pkg::ATC_REF_OFF:  ref_event = 1'b1;        // [R1]
            atc_pkg::ATC_REF_DIG:  ref_event = ref_dig_hit; // [R2]
            atc_pkg::ATC_REF_SOFT: ref_event = soft_pend;   // [R7]
            atc_pkg::ATC_REF_IQ:   ref_event = iq_hit;      // [R12]
            default:               ref_event = 1'b0;
        endcase
    end
    wire logic ref_go = in_ref & ref_event & ~abort_wr;

    // Sequencer next state
    always_comb
    begin
        next_st = st;
        case (st)
            atc_pkg::ST_IDLE:
            begin
                if (arm_wr & ~abort_wr)
                begin
                    // Disabled start skips waiting
                    next_st = start_dig ? atc_pkg::ST_WAIT_START
                                        : atc_pkg::ST_PRE_FILL; // [R13]
                end
            end
            atc_pkg::ST_WAIT_START:
            begin
                if (abort_wr)
                begin
                    next_st = atc_pkg::ST_IDLE;
                end
                else if (start_dig_hit | ~start_dig)
                begin
                    next_st = atc_pkg::ST_PRE_FILL; // [R15]
                end
            end
            atc_pkg::ST_PRE_FILL:
            begin
                if (abort_wr)
                begin
                    next_st = atc_pkg::ST_IDLE;
                end
                else if (pre_full)
                begin
                    next_st = atc_pkg::ST_WAIT_REF; // [R6]
                end
            end
            atc_pkg::ST_WAIT_REF:
            begin
                // Stays here until the event, soft mode included
                if (abort_wr | ref_go)
                begin
                    next_st = atc_pkg::ST_IDLE; // [R8]
                end
            end
            default:
            begin
                next_st = atc_pkg::ST_IDLE;
            end
        endcase
    end

    // Read data mux
    wire logic [31:0] stat_word = {25'h0, iq_err, soft_pend, ref_seen, st};
    wire logic [31:0] rd_word =
        hit_ref  ? {16'h0, ref_cfg}   :
        hit_strt ? {26'h0, start_cfg} :
        hit_pre  ? {16'h0, pretrig}   :
        hit_lvl  ? iq_level           :
        hit_stat ? stat_word          : 32'h0000_0000;
    wire logic arm_go = (st == atc_pkg::ST_IDLE) & (next_st != atc_pkg::ST_IDLE);

    // APB answer: ready in the first access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (pclk_en)
        begin
            pready  <= setup;
            pslverr <= setup & ~addr_ok;
            prdata  <= (setup & ~pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    // Configuration writes, whole field set replaced
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ref_cfg   <= atc_pkg::REF_CFG_RST;
            start_cfg <= atc_pkg::START_CFG_RST;
            pretrig   <= atc_pkg::PRETRIG_RST;
            iq_level  <= atc_pkg::IQ_LEVEL_RST;
        end
        else if (wr)
        begin
            if (hit_ref)
            begin
                ref_cfg <= pwdata[15:0]; // [R14]
            end
            if (hit_strt)
            begin
                start_cfg <= pwdata[5:0];
            end
            if (hit_pre)
            begin
                pretrig <= pwdata[15:0];
            end
            if (hit_lvl)
            begin
                iq_level <= pwdata;
            end
        end
    end

    // Sequencer, counters and flags
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st            <= atc_pkg::ST_IDLE;
            pre_cnt       <= 16'h0000;
            soft_pend     <= 1'b0;
            ref_seen      <= 1'b0;
            lines_prev    <= '0;
            iq_prev_above <= 1'b0;
            iq_primed     <= 1'b0;
            acq_run       <= 1'b0;
            ref_mark      <= 1'b0;
        end
        else if (pclk_en)
        begin
            st         <= next_st;
            lines_prev <= lines_f;
            acq_run    <= next_st != atc_pkg::ST_IDLE;
            ref_mark   <= ref_go;
            // Count samples only while filling the window
            if (arm_go)
            begin
                pre_cnt <= 16'h0000;
            end
            else if ((st == atc_pkg::ST_PRE_FILL) & iq_in.valid & ~pre_full)
            begin
                pre_cnt <= pre_cnt + 16'h0001;
            end
            // A new command wins over its consumption
            soft_pend <= soft_wr | (soft_pend & ~(arm_go | abort_wr |
                         (in_ref & (ref_mode == atc_pkg::ATC_REF_SOFT))));
            // Seen flag set by a mark, cleared by a new arm
            ref_seen <= ref_go | (ref_seen & ~arm_go);
            // Power history restarts with each record
            if (arm_go)
            begin
                iq_primed <= 1'b0;
            end
            else if (iq_in.valid)
            begin
                iq_primed     <= 1'b1;
                iq_prev_above <= iq_above; // [R11]
            end
        end
    end

    // Checks on the sequencer
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_ref_off_nowait: assert property ( // [R1]
        pclk_en && in_ref && ref_mode == atc_pkg::ATC_REF_OFF && !abort_wr
        |=> ref_mark && st == atc_pkg::ST_IDLE)
        else $error("disabled reference did not mark at once");

    a_dig_ref_fire: assert property ( // [R2]
        pclk_en && in_ref && ref_mode == atc_pkg::ATC_REF_DIG && !abort_wr &&
        ref_src == 4'h2 && !lines_prev[2] && lines_f[2] && !ref_fall
        |=> ref_mark ##1 !ref_mark)
        else $error("digital reference edge missed");

    a_star_source: assert property ( // [R3] [R4]
        pclk_en && in_ref && ref_mode == atc_pkg::ATC_REF_DIG && !abort_wr &&
        ref_src == atc_pkg::SRC_LAST && !ref_fall && !lines_prev[10] && lines_f[10]
        |=> ref_mark)
        else $error("star line rising edge missed");

    a_edge_polarity: assert property ( // [R5]
        pclk_en && in_ref && ref_mode == atc_pkg::ATC_REF_DIG && ref_src == 4'h0 &&
        (ref_fall ? !(lines_prev[0] && !lines_f[0]) : !(!lines_prev[0] && lines_f[0]))
        |=> !ref_mark)
        else $error("reference fired on the wrong edge");

    a_pretrig_kept: assert property ( // [R6]
        in_ref |-> pre_cnt >= pretrig)
        else $error("reference armed before pretrigger filled");

    a_soft_ref_fire: assert property ( // [R7]
        pclk_en && in_ref && ref_mode == atc_pkg::ATC_REF_SOFT && soft_pend &&
        !abort_wr && !soft_wr
        |=> ref_mark && !soft_pend)
        else $error("software reference not taken");

    a_soft_ref_hold: assert property ( // [R8]
        pclk_en && in_ref && ref_mode == atc_pkg::ATC_REF_SOFT && !soft_pend && !abort_wr
        |=> !ref_mark && in_ref)
        else $error("software reference left without command");

    a_iq_cross_fire: assert property ( // [R9] [R11] [R12]
        pclk_en && in_ref && ref_mode == atc_pkg::ATC_REF_IQ && iq_in.valid &&
        iq_src_ok && iq_primed && !abort_wr && !slope_fall &&
        !iq_prev_above && iq_power > {1'b0, iq_level}
        |=> ref_mark)
        else $error("upward power crossing missed");

    a_iq_src_block: assert property ( // [R10]
        pclk_en && in_ref && ref_mode == atc_pkg::ATC_REF_IQ && !iq_src_ok
        |=> !ref_mark)
        else $error("power trigger fired on a bad source");

    a_start_off_go: assert property ( // [R13]
        pclk_en && st == atc_pkg::ST_IDLE && arm_wr && !abort_wr && !start_dig
        |=> st == atc_pkg::ST_PRE_FILL && acq_run)
        else $error("disabled start did not begin at once");

    a_start_edge_hold: assert property ( // [R15]
        pclk_en && st == atc_pkg::ST_WAIT_START && start_dig && !start_dig_hit &&
        !abort_wr
        |=> st == atc_pkg::ST_WAIT_START)
        else $error("start left without its edge");

    a_mode_replace: assert property ( // [R14]
        wr && hit_ref |=> ref_cfg == $past(pwdata[15:0]))
        else $error("reference configuration not replaced");
endmodule
`default_nettype wire

// ===== atc_pkg.sv
// Constants, types and register map for the acquisition trigger control.
// Assumes one 40 MHz clock and an APB master with 32-bit data.
// How it works
// [R1] Disabled reference places reference point without waiting
// [R2] Digital reference waits for edge on line
// [R3] Sources: two function inputs, backplane lines 0-7
// [R4] Backplane star line is also a source
// [R5] Edge setting picks rising or falling
// [R6] Pretrigger sample count kept before reference
// [R7] Software command marks reference in software mode
// [R8] Software mode waits until command arrives
// [R9] IQ power crossing the level marks reference
// [R10] Host sets IQ source index to zero
// [R11] Slope picks upward or downward power crossing
// [R12] Level sets the power threshold to cross
// [R13] Disabled start begins acquisition at once
// [R14] One reference mode; new setting replaces all
// [R15] Digital start waits for edge on source
`default_nettype none
package atc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL      = 8'h00;
    localparam logic [7:0] OFF_REF_CFG   = 8'h04;
    localparam logic [7:0] OFF_START_CFG = 8'h08;
    localparam logic [7:0] OFF_PRETRIG   = 8'h0c;
    localparam logic [7:0] OFF_IQ_LEVEL  = 8'h10;
    localparam logic [7:0] OFF_STATUS    = 8'h14;
    // Control bits, write one to act
    localparam int CTRL_ARM   = 0;
    localparam int CTRL_SOFT  = 1;
    localparam int CTRL_ABORT = 2;
    // Reference configuration fields
    localparam int REF_MODE_LSB  = 0;
    localparam int REF_SRC_LSB   = 2;
    localparam int REF_EDGE_BIT  = 6;
    localparam int REF_SLOPE_BIT = 7;
    localparam int REF_IQSRC_LSB = 8;
    // Start configuration fields
    localparam int START_MODE_BIT = 0;
    localparam int START_SRC_LSB  = 1;
    localparam int START_EDGE_BIT = 5;
    // Status fields
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_SEEN_BIT  = 4;
    localparam int STAT_SOFT_BIT  = 5;
    localparam int STAT_IQERR_BIT = 6;
    // Reset values
    localparam logic [15:0] REF_CFG_RST   = 16'h0000;
    localparam logic [5:0]  START_CFG_RST = 6'h00;
    localparam logic [15:0] PRETRIG_RST   = 16'h0000;
    localparam logic [31:0] IQ_LEVEL_RST  = 32'h0000_0000;
    // Trigger line indices
    localparam int          NUM_LINES = 11;
    localparam logic [3:0]  SRC_LAST  = 4'ha;
    localparam logic [7:0]  IQ_SRC_ONLY = 8'h00;
    // Reference trigger modes
    typedef enum logic [1:0] {
        ATC_REF_OFF  = 2'h0,
        ATC_REF_DIG  = 2'h1,
        ATC_REF_SOFT = 2'h2,
        ATC_REF_IQ   = 2'h3
    } atc_ref_mode_t;
    // Record sequencer states
    typedef enum logic [3:0] {
        ST_IDLE       = 4'h1,
        ST_WAIT_START = 4'h2,
        ST_PRE_FILL   = 4'h4,
        ST_WAIT_REF   = 4'h8
    } atc_state_t;
    // Trigger lines: star at top, backplane 0-7, function inputs 0-1
    typedef struct packed {
        logic       star;
        logic [7:0] bp;
        logic       function_input_one;
        logic       function_input_zero;
    } atc_lines_t;
    // One IQ sample with its strobe
    typedef struct packed {
        logic               valid;
        logic signed [15:0] i;
        logic signed [15:0] q;
    } atc_iq_t;
endpackage
`default_nettype wire

// ===== atc_pin_sync.sv
// Three-stage synchroniser with agreement filter for trigger pins.
// Assumes pins are asynchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module atc_pin_sync
(
    // Clock and reset
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          pclk_en,
    // Pins and filtered levels
    input  wire logic [atc_pkg::NUM_LINES-1:0] pin_in,
    output logic      [atc_pkg::NUM_LINES-1:0] level_out
);
    genvar n;
    generate
        for (n = 0; n < atc_pkg::NUM_LINES; n = n + 1)
        begin : g_line
            logic s1; // Metastable stage, read only by s2
            logic s2; // Second stage
            logic s3; // Third stage
            logic lv; // Accepted level
            // Shift and accept once stages two and three agree
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                    lv <= 1'b0;
                end
                else if (pclk_en)
                begin
                    s1 <= pin_in[n];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3)
                    begin
                        lv <= s3;
                    end
                end
            end
            assign level_out[n] = lv;
        end
    endgenerate
endmodule
`default_nettype wire

// ===== atc_far_side.sv
// Far-side model: trigger pins and IQ sample source facing the trigger control.
// Assumes the bench sets the wanted levels; the model launches them after a pclk edge.
`timescale 1ns/1ps
`default_nettype none
module atc_far_side
(
    // Clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // Wanted pin levels and samples
    input  wire atc_pkg::atc_lines_t want_lines,
    input  wire atc_pkg::atc_iq_t    want_iq,
    // Pins and samples towards the block
    output var atc_pkg::atc_lines_t  trig_lines,
    output var atc_pkg::atc_iq_t     iq_in
);
    // Pins follow the wanted levels; idle sample slots carry a changing pattern,
    // so that a stale sample can never pass for a fresh one
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trig_lines <= '0;
            iq_in      <= '0;
        end
        else
        begin
            trig_lines <= want_lines;
            // Valid sample passes whole; otherwise invert the last payload
            if (want_iq.valid)
                iq_in <= want_iq;
            else
                iq_in <= {1'b0, ~iq_in.i, ~iq_in.q};
        end
    end
endmodule
`default_nettype wire

// ===== acquisition_trigger_control_tb.sv
// Self-checking bench for the trigger control: APB set-up, pins and IQ traffic.
// Assumes atc_top and atc_far_side; clock 40 MHz, reset held 16 cycles.
`timescale 1ns/1ps
`default_nettype none
module acquisition_trigger_control_tb;
    // Clock, reset and APB master
    logic                pclk    = 1'b0;
    logic                presetn = 1'b0;
    logic                pclk_en = 1'b1;
    logic                psel    = 1'b0;
    logic                penable = 1'b0;
    logic                pwrite  = 1'b0;
    logic [7:0]          paddr   = 8'h00;
    logic [31:0]         pwdata  = 32'h0000_0000;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    // Far-side requests and block outputs
    atc_pkg::atc_lines_t want_lines = '0;
    atc_pkg::atc_iq_t    want_iq    = '0;
    atc_pkg::atc_lines_t trig_lines;
    atc_pkg::atc_iq_t    iq_in;
    logic                acq_run;
    logic                ref_mark;
    // Bookkeeping
    int                  n_mismatch = 0;
    int                  n_checks   = 0;
    logic [31:0]         rdv;
    logic                errv;
    logic                got;
    int                  cyc;

    // Block under test; clock enable from the bench
    atc_top i_atc_top (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .trig_lines(trig_lines), .iq_in(iq_in),
        .acq_run(acq_run), .ref_mark(ref_mark));
    // Pins and sample source
    atc_far_side i_atc_far_side (.pclk(pclk), .presetn(presetn), .want_lines(want_lines),
        .want_iq(want_iq), .trig_lines(trig_lines), .iq_in(iq_in));

    // Clock generator
    always #12.5 pclk = ~pclk;

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer: setup, access, hold until pready
    task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr_en;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait until pready; the watchdog ends a wait that never finishes
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rdv     = prdata;
        errv    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rdv, exp);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Watch for the reference pulse for a bounded number of cycles
    task automatic wait_mark(input int limit);
        got = 1'b0;
        cyc = 0;
        while (!got && cyc < limit)
        begin
            @(negedge pclk);
            if (ref_mark === 1'b1)
                got = 1'b1;
            else
                cyc++;
        end
    endtask

    // Abort any record, then arm a new one
    task automatic arm;
        wr(atc_pkg::OFF_CTRL, 32'h1 << atc_pkg::CTRL_ABORT);
        wr(atc_pkg::OFF_CTRL, 32'h1 << atc_pkg::CTRL_ARM);
    endtask

    // One valid IQ sample for one cycle
    task automatic sample(input logic signed [15:0] i, input logic signed [15:0] q);
        @(posedge pclk);
        want_iq <= {1'b1, i, q};
        @(posedge pclk);
        want_iq <= '0;
    endtask

    // Reset values, unmapped and read-only places
    task automatic t_reset;
        rd(atc_pkg::OFF_REF_CFG, 32'h0000_0000);
        rd(atc_pkg::OFF_START_CFG, 32'h0000_0000);
        rd(atc_pkg::OFF_PRETRIG, 32'h0000_0000);
        rd(atc_pkg::OFF_IQ_LEVEL, 32'h0000_0000);
        rd(atc_pkg::OFF_CTRL, 32'h0000_0000);
        wr(atc_pkg::OFF_STATUS, 32'hffff_ffff);
        rd(atc_pkg::OFF_STATUS, 32'h0000_0001);
        rd(8'h18, 32'h0000_0000);
        check({31'h0, errv}, 32'h1);
    endtask

    // Both triggers off: mark follows the arm at once
    task automatic t_off;
        arm;
        wait_mark(8);
        check(32'(cyc), 32'h2);
        @(negedge pclk);
        check({31'h0, acq_run}, 32'h0);
    endtask

    // Pretrigger count holds the mark back until enough samples
    task automatic t_pretrig;
        wr(atc_pkg::OFF_PRETRIG, 32'h3);
        arm;
        wait_mark(10);
        check({31'h0, got}, 32'h0);
        rd(atc_pkg::OFF_STATUS, 32'h0000_0004);
        sample(16'sh0001, 16'sh0001);
        sample(16'sh0001, 16'sh0001);
        // A sample met while the clock enable is low must not count
        idle(1);
        pclk_en <= 1'b0;
        sample(16'sh0001, 16'sh0001);
        idle(1);
        pclk_en <= 1'b1;
        wait_mark(8);
        check({31'h0, got}, 32'h0);
        sample(16'sh0001, 16'sh0001);
        wait_mark(8);
        check({31'h0, got}, 32'h1);
        wr(atc_pkg::OFF_PRETRIG, 32'h0);
    endtask

    // Every source, alternating edge; a different line must not fire
    task automatic t_digital;
        for (int s = 0; s < atc_pkg::NUM_LINES; s++)
        begin
            want_lines <= s[0] ? '1 : '0;
            idle(8);
            wr(atc_pkg::OFF_REF_CFG, 32'(s) << atc_pkg::REF_SRC_LSB
                | 32'(s % 2) << atc_pkg::REF_EDGE_BIT | 32'(atc_pkg::ATC_REF_DIG));
            arm;
            want_lines[(s + 1) % atc_pkg::NUM_LINES] <= ~s[0];
            wait_mark(12);
            check({31'h0, got}, 32'h0);
            want_lines[s] <= ~s[0];
            wait_mark(12);
            check({31'h0, got}, 32'h1);
        end
        want_lines <= '0;
    endtask

    // Software mode replaces digital; pins ignored, command releases
    task automatic t_soft;
        wr(atc_pkg::OFF_REF_CFG, 32'(atc_pkg::ATC_REF_DIG));
        wr(atc_pkg::OFF_REF_CFG, 32'(atc_pkg::ATC_REF_SOFT));
        idle(8);
        arm;
        want_lines.function_input_zero <= 1'b1;
        wait_mark(20);
        check({31'h0, got}, 32'h0);
        rd(atc_pkg::OFF_STATUS, 32'h0000_0008);
        wr(atc_pkg::OFF_CTRL, 32'h1 << atc_pkg::CTRL_SOFT);
        wait_mark(6);
        check({31'h0, got}, 32'h1);
        want_lines <= '0;
    endtask

    // Power crossings both ways, strict level, refused source index
    task automatic t_iq;
        wr(atc_pkg::OFF_IQ_LEVEL, 32'h0000_0064);
        wr(atc_pkg::OFF_REF_CFG, 32'(atc_pkg::ATC_REF_IQ));
        arm;
        sample(16'sh0005, 16'sh0005);
        sample(16'sh000a, 16'sh0000);
        wait_mark(8);
        check({31'h0, got}, 32'h0);
        sample(16'sh000a, 16'sh0005);
        wait_mark(8);
        check({31'h0, got}, 32'h1);
        wr(atc_pkg::OFF_REF_CFG, 32'h1 << atc_pkg::REF_SLOPE_BIT | 32'(atc_pkg::ATC_REF_IQ));
        arm;
        sample(16'sh000a, 16'sh0005);
        wait_mark(8);
        check({31'h0, got}, 32'h0);
        sample(16'sh0005, 16'shfffb);
        wait_mark(8);
        check({31'h0, got}, 32'h1);
        wr(atc_pkg::OFF_REF_CFG, 32'h1 << atc_pkg::REF_IQSRC_LSB | 32'(atc_pkg::ATC_REF_IQ));
        arm;
        rd(atc_pkg::OFF_STATUS, 32'h0000_0048);
        sample(16'sh0005, 16'sh0005);
        sample(16'sh000a, 16'sh0005);
        wait_mark(8);
        check({31'h0, got}, 32'h0);
    endtask

    // Digital start on backplane line 0 holds the record off
    task automatic t_start;
        wr(atc_pkg::OFF_REF_CFG, 32'h0);
        wr(atc_pkg::OFF_START_CFG, 32'h2 << atc_pkg::START_SRC_LSB | 32'h1);
        idle(8);
        arm;
        wait_mark(12);
        check({31'h0, got}, 32'h0);
        check({31'h0, acq_run}, 32'h1);
        rd(atc_pkg::OFF_STATUS, 32'h0000_0002);
        want_lines.bp[0] <= 1'b1;
        wait_mark(16);
        check({31'h0, got}, 32'h1);
        wr(atc_pkg::OFF_START_CFG, 32'h0);
    endtask

    // Counts, verdict and end of run
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_off;
        t_pretrig;
        t_digital;
        t_soft;
        t_iq;
        t_start;
        tally_and_finish;
    end

    // Watchdog well beyond the expected run length
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
